// file: rtl/can_conf_pkg.sv
// constants for the can fault confinement and node manager block
package can_conf_pkg;
    // ------------------------------------------------------------
    // counter widths and thresholds
    // ------------------------------------------------------------
    localparam int          CNT_W          = 9;
    localparam logic [8:0]  PASSIVE_LIMIT  = 9'h07F;  // passive above this
    localparam logic [8:0]  BUSOFF_LIMIT   = 9'h0FF;  // bus-off above this
    localparam logic [8:0]  CNT_RESET      = 9'h000;
    localparam logic [8:0]  TX_ERR_STEP    = 9'h008;
    localparam logic [8:0]  RX_ERR_STEP    = 9'h001;
    localparam logic [8:0]  RX_PRIMARY_STEP= 9'h008;
    localparam logic [8:0]  OK_STEP        = 9'h001;
    // ------------------------------------------------------------
    // node manager
    // ------------------------------------------------------------
    localparam int          NODE_W         = 7;
    localparam logic [6:0]  FIRST_NODE     = 7'h01;
    localparam logic [6:0]  LAST_NODE      = 7'h7F;
    // guard answer wait, in microseconds
    localparam int          GUARD_WAIT_US  = 100;
    localparam int          CLK_MHZ        = 200;
    localparam int          GUARD_WAIT_CYC = GUARD_WAIT_US * CLK_MHZ;

    typedef enum logic [1:0]
    {
        ERR_ACTIVE  = 2'b00,
        ERR_PASSIVE = 2'b01,
        ERR_BUSOFF  = 2'b10
    } conf_state_e;

    typedef enum logic [2:0]
    {
        MG_IDLE    = 3'b000,
        MG_GUARD   = 3'b001,
        MG_WAIT    = 3'b010,
        MG_NEXT    = 3'b011,
        MG_DONE    = 3'b100
    } mgr_state_e;
endpackage : can_conf_pkg

// file: rtl/can_error_state_node_mgmt.sv
// can fault confinement, bus-off recovery and node guarding scan manager
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - error count above 127 makes the controller error-passive
// - error count above 255 means bus-off; bus outputs then stay recessive
// - passive clears by itself once both counts fall back to 127
// - bus-off holds until a restart command arrives with the 128th idle run, or until device reset
// - remote supervision uses node guarding requests, never heartbeat
// - no data exchange with a scanned node before it is connected
// - own-family nodes connect automatically after scan; others need connect request
// - while reset is held the controller drives nothing onto the bus
module can_error_state_node_mgmt #(
    parameter int GUARD_WAIT = can_conf_pkg::GUARD_WAIT_CYC
)(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // error events from the bit engine, one-cycle pulses
    input  wire logic        tx_error,
    input  wire logic        rx_error,
    input  wire logic        rx_error_primary,
    input  wire logic        tx_ok,
    input  wire logic        rx_ok,
    input  wire logic        idle_run,          // 11 recessive bits seen, one pulse per run
    // commands
    input  wire logic        link_restart_command,
    input  wire logic        network_discovery_command,
    input  wire logic        connect_request,
    input  wire logic [6:0]  connect_node,
    // node guarding traffic
    input  wire logic        guard_answer,      // answer seen for guard_node
    input  wire logic        guard_answer_family, // answer comes from own family
    input  wire logic        data_request,
    input  wire logic [6:0]  data_node,
    // bus side
    input  wire logic        tx_bit,
    output logic             can_tx,
    // status
    output logic [8:0]       tx_err_count,
    output logic [8:0]       rx_err_count,
    output logic             error_passive,
    output logic             bus_off,
    output logic             guard_request,
    output logic [6:0]       guard_node,
    output logic             scan_busy,
    output logic             scan_done,
    output logic             data_grant,
    output logic [127:0]     found_map,
    output logic [127:0]     connected_map
);
    // ------------------------------------------------------------
    // fault confinement
    // ------------------------------------------------------------
    can_conf_pkg::conf_state_e conf_reg, conf_next;
    logic [8:0]  tec_reg, tec_next;
    logic [8:0]  rec_reg, rec_next;
    logic [7:0]  idle_runs_reg, idle_runs_next;
    logic [9:0]  tec_up, rec_up, rec_upp;
    logic        over_off, over_passive, recovered;

    // saturating sums are one bit wider to see the crossing
    assign tec_up  = {1'b0, tec_reg} + {1'b0, can_conf_pkg::TX_ERR_STEP};
    assign rec_up  = {1'b0, rec_reg} + {1'b0, can_conf_pkg::RX_ERR_STEP};
    assign rec_upp = {1'b0, rec_reg} + {1'b0, can_conf_pkg::RX_PRIMARY_STEP};
    // either count beyond the off threshold takes the node off the bus
    assign over_off     = (tec_next > can_conf_pkg::BUSOFF_LIMIT) ||
                          (rec_next > can_conf_pkg::BUSOFF_LIMIT);
    assign over_passive = (tec_next > can_conf_pkg::PASSIVE_LIMIT) ||
                          (rec_next > can_conf_pkg::PASSIVE_LIMIT);
    assign recovered    = (idle_runs_reg == 8'h7F) && idle_run;                          // 128 idle runs

    // counter steps, error wins over success in the same cycle
    always_comb
    begin
        tec_next       = tec_reg;
        rec_next       = rec_reg;
        idle_runs_next = idle_runs_reg;
        conf_next      = conf_reg;
        if (conf_reg == can_conf_pkg::ERR_BUSOFF)
        begin
            if (idle_run)
                idle_runs_next = idle_runs_reg + 8'h01;
            if (link_restart_command && recovered)
            begin
                tec_next       = can_conf_pkg::CNT_RESET;
                rec_next       = can_conf_pkg::CNT_RESET;
                idle_runs_next = 8'h00;
                conf_next      = can_conf_pkg::ERR_ACTIVE;
            end
        end
        else
        begin
            if (tx_error)
                tec_next = tec_up[9] ? 9'h1FF : tec_up[8:0];
            else if (tx_ok && tec_reg != can_conf_pkg::CNT_RESET)
                tec_next = tec_reg - can_conf_pkg::OK_STEP;
            if (rx_error_primary)
                rec_next = rec_upp[9] ? 9'h1FF : rec_upp[8:0];
            else if (rx_error)
                rec_next = rec_up[9] ? 9'h1FF : rec_up[8:0];
            else if (rx_ok && rec_reg > can_conf_pkg::PASSIVE_LIMIT)
                rec_next = can_conf_pkg::PASSIVE_LIMIT;
            else if (rx_ok && rec_reg != can_conf_pkg::CNT_RESET)
                rec_next = rec_reg - can_conf_pkg::OK_STEP;
            if (over_off)
            begin
                conf_next      = can_conf_pkg::ERR_BUSOFF;
                idle_runs_next = 8'h00;
            end
            else if (over_passive)
                conf_next = can_conf_pkg::ERR_PASSIVE;
            else
                conf_next = can_conf_pkg::ERR_ACTIVE;
        end
    end

    // confinement registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            conf_reg      <= can_conf_pkg::ERR_ACTIVE;
            tec_reg       <= can_conf_pkg::CNT_RESET;
            rec_reg       <= can_conf_pkg::CNT_RESET;
            idle_runs_reg <= 8'h00;
        end
        else
        begin
            conf_reg      <= conf_next;
            tec_reg       <= tec_next;
            rec_reg       <= rec_next;
            idle_runs_reg <= idle_runs_next;
        end
    end

    // ------------------------------------------------------------
    // network scan by node guarding
    // ------------------------------------------------------------
    can_conf_pkg::mgr_state_e mg_reg, mg_next;
    logic [6:0]   node_reg, node_next;
    logic [31:0]  wait_reg, wait_next;
    logic [127:0] found_reg, found_next;
    logic [127:0] conn_reg, conn_next;
    logic         on_bus, wait_over, last_node, scan_idle;

    assign on_bus    = (conf_reg != can_conf_pkg::ERR_BUSOFF);
    assign wait_over = (wait_reg >= GUARD_WAIT - 1);
    assign last_node = (node_reg == can_conf_pkg::LAST_NODE);
    // no data traffic while a scan is still running, connections count only once it is over
    assign scan_idle = (mg_reg == can_conf_pkg::MG_IDLE);

    // scan sequencer, one guard request per node id
    always_comb
    begin
        mg_next    = mg_reg;
        node_next  = node_reg;
        wait_next  = wait_reg;
        found_next = found_reg;
        conn_next  = conn_reg;
        case (mg_reg)
            can_conf_pkg::MG_IDLE:
            begin
                if (network_discovery_command && on_bus)
                begin
                    mg_next    = can_conf_pkg::MG_GUARD;
                    node_next  = can_conf_pkg::FIRST_NODE;
                    found_next = '0;
                    conn_next  = '0;
                end
                else if (connect_request && found_reg[connect_node])
                    conn_next[connect_node] = 1'b1;
            end
            can_conf_pkg::MG_GUARD:
            begin
                mg_next   = can_conf_pkg::MG_WAIT;
                wait_next = 32'h0;
            end
            can_conf_pkg::MG_WAIT:
            begin
                wait_next = wait_reg + 32'h1;
                if (guard_answer)
                begin
                    found_next[node_reg] = 1'b1;
                    mg_next = can_conf_pkg::MG_NEXT;
                    if (guard_answer_family)
                        conn_next[node_reg] = 1'b1;
                end
                else if (wait_over)
                    mg_next = can_conf_pkg::MG_NEXT;
            end
            can_conf_pkg::MG_NEXT:
            begin
                node_next = node_reg + 7'h01;
                mg_next   = last_node ? can_conf_pkg::MG_DONE : can_conf_pkg::MG_GUARD;
            end
            can_conf_pkg::MG_DONE:
                mg_next = can_conf_pkg::MG_IDLE;
            default:
                mg_next = can_conf_pkg::MG_IDLE;
        endcase
        if (!on_bus && mg_reg != can_conf_pkg::MG_IDLE)
            mg_next = can_conf_pkg::MG_IDLE;                                             // abort on bus-off
    end

    // manager registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mg_reg    <= can_conf_pkg::MG_IDLE;
            node_reg  <= can_conf_pkg::FIRST_NODE;
            wait_reg  <= 32'h0;
            found_reg <= '0;
            conn_reg  <= '0;
        end
        else
        begin
            mg_reg    <= mg_next;
            node_reg  <= node_next;
            wait_reg  <= wait_next;
            found_reg <= found_next;
            conn_reg  <= conn_next;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            can_tx        <= 1'b1;
            tx_err_count  <= can_conf_pkg::CNT_RESET;
            rx_err_count  <= can_conf_pkg::CNT_RESET;
            error_passive <= 1'b0;
            bus_off       <= 1'b0;
            guard_request <= 1'b0;
            guard_node    <= can_conf_pkg::FIRST_NODE;
            scan_busy     <= 1'b0;
            scan_done     <= 1'b0;
            data_grant    <= 1'b0;
            found_map     <= '0;
            connected_map <= '0;
        end
        else
        begin
            can_tx        <= (conf_next == can_conf_pkg::ERR_BUSOFF) ? 1'b1 : tx_bit;
            tx_err_count  <= tec_next;
            rx_err_count  <= rec_next;
            error_passive <= (conf_next == can_conf_pkg::ERR_PASSIVE);
            bus_off       <= (conf_next == can_conf_pkg::ERR_BUSOFF);
            guard_request <= (mg_next == can_conf_pkg::MG_GUARD);
            guard_node    <= node_next;
            scan_busy     <= (mg_next != can_conf_pkg::MG_IDLE);
            scan_done     <= (mg_next == can_conf_pkg::MG_DONE);
            data_grant    <= data_request && conn_reg[data_node] && on_bus && scan_idle;
            found_map     <= found_next;
            connected_map <= conn_next;
        end
    end
endmodule : can_error_state_node_mgmt

`default_nettype wire

// file: sim/can_node_model.sv
// remote guarded nodes answering the scan manager
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
    // clock
    input  wire logic       mclk,
    // guard traffic
    input  wire logic       guard_request,
    input  wire logic [6:0] guard_node,
    output logic            guard_answer,
    output logic            guard_answer_family
);
    logic [3:0] dly_reg = 4'h0;
    logic       fam_reg = 1'b0;
    initial guard_answer = 1'b0;
    initial guard_answer_family = 1'b0;
    // node 3 is own family and prompt, node 5 is foreign and slow; ids unique, one shared bit rate
    always @(posedge mclk)
    begin
        guard_answer <= 1'b0;
        if (guard_request && guard_node == 7'h03)
        begin
            dly_reg <= 4'h1;
            fam_reg <= 1'b1;
        end
        else if (guard_request && guard_node == 7'h05)
        begin
            dly_reg <= 4'h3;
            fam_reg <= 1'b0;
        end
        else if (dly_reg != 4'h0)
        begin
            dly_reg <= dly_reg - 4'h1;
            guard_answer <= (dly_reg == 4'h1);
        end
        // qualifier only means something with an answer; otherwise it toggles
        guard_answer_family <= (dly_reg == 4'h1) ? fam_reg : ~guard_answer_family;
    end
endmodule : can_node_model
`default_nettype wire

// file: sim/can_error_state_node_mgmt_chk.sv
// port assertions for the confinement and scan manager block
`timescale 1ns/1ps
`default_nettype none
module can_error_state_node_mgmt_chk #(
    parameter int GUARD_WAIT = 8
)(
    // clock and reset
    input wire logic         mclk,
    input wire logic         rst,
    // requests
    input wire logic         tx_error,
    input wire logic         link_restart_command,
    input wire logic         data_request,
    input wire logic [6:0]   data_node,
    // outputs
    input wire logic         can_tx,
    input wire logic [8:0]   tx_err_count,
    input wire logic [8:0]   rx_err_count,
    input wire logic         error_passive,
    input wire logic         bus_off,
    input wire logic         guard_request,
    input wire logic         scan_busy,
    input wire logic         data_grant,
    input wire logic [127:0] connected_map
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_passive;
        !bus_off |-> error_passive == (tx_err_count > 9'h07F || rx_err_count > 9'h07F);
    endproperty
    a_passive: assert property (p_passive) else $error("passive flag wrong");
    property p_off_set;
        tx_err_count > 9'h0FF || rx_err_count > 9'h0FF |-> bus_off;
    endproperty
    a_off_set: assert property (p_off_set) else $error("bus-off missing");
    property p_off_quiet;
        bus_off |-> can_tx;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("bus driven in bus-off");
    property p_rst_quiet;
        disable iff (1'b0) rst |=> can_tx && !bus_off && tx_err_count == 9'h000;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("bus driven in reset");
    property p_off_hold;
        bus_off && !link_restart_command |=> bus_off;
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("bus-off left alone");
    property p_restart;
        $fell(bus_off) |-> tx_err_count == 9'h000 && rx_err_count == 9'h000 && !error_passive;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not clean");
    property p_tx_step;
        tx_error && !bus_off |=> tx_err_count == $past(tx_err_count) + 9'h008;
    endproperty
    a_tx_step: assert property (p_tx_step) else $error("tx count step wrong");
    property p_grant_on;
        data_request && !bus_off && !scan_busy && connected_map[data_node] |=> data_grant;
    endproperty
    a_grant_on: assert property (p_grant_on) else $error("grant missing");
    property p_grant_off;
        !data_request |=> !data_grant;
    endproperty
    a_grant_off: assert property (p_grant_off) else $error("grant uncaused");
    property p_guard;
        guard_request |=> !guard_request;
    endproperty
    a_guard: assert property (p_guard) else $error("guard request too long");
endmodule : can_error_state_node_mgmt_chk
bind can_error_state_node_mgmt can_error_state_node_mgmt_chk #(.GUARD_WAIT(GUARD_WAIT)) chk (.mclk, .rst,
    .tx_error, .link_restart_command, .data_request, .data_node, .can_tx, .tx_err_count, .rx_err_count,
    .error_passive, .bus_off, .guard_request, .scan_busy, .data_grant, .connected_map);
`default_nettype wire

// file: sim/can_error_state_node_mgmt_tb.sv
// testbench for the confinement and scan manager block
`timescale 1ns/1ps
`default_nettype none
module can_error_state_node_mgmt_tb;
    logic         mclk = 1'b0;
    logic         rst = 1'b1;
    logic [6:0]   ev = 7'h00;  // restart idle rx_ok tx_ok rx_prim rx_err tx_err
    logic         network_discovery_command = 1'b0, connect_request = 1'b0, data_request = 1'b0;
    logic [6:0]   connect_node = 7'h00, data_node = 7'h00;
    logic         tx_bit = 1'b0;
    wire logic    can_tx, error_passive, bus_off, guard_request, scan_busy, scan_done, data_grant;
    wire logic    guard_answer, guard_answer_family;
    wire logic [8:0] tx_err_count, rx_err_count;
    wire logic [6:0] guard_node;
    wire logic [127:0] found_map, connected_map;
    int           miscompares = 0, cmp_count = 0, guards = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (guard_request === 1'b1) guards++;
    can_error_state_node_mgmt #(.GUARD_WAIT(8)) dut (.mclk, .rst, .tx_error(ev[0]), .rx_error(ev[1]),
        .rx_error_primary(ev[2]), .tx_ok(ev[3]), .rx_ok(ev[4]), .idle_run(ev[5]), .link_restart_command(ev[6]),
        .network_discovery_command, .connect_request, .connect_node, .guard_answer, .guard_answer_family,
        .data_request, .data_node, .tx_bit, .can_tx, .tx_err_count, .rx_err_count, .error_passive, .bus_off,
        .guard_request, .guard_node, .scan_busy, .scan_done, .data_grant, .found_map, .connected_map);
    can_node_model far (.mclk, .guard_request, .guard_node, .guard_answer, .guard_answer_family);
    task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] seen);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic pulse(input logic [6:0] v, input int n);
        repeat (n)
        begin
            @(negedge mclk) ev = v;
            @(negedge mclk) ev = 7'h00;
        end
    endtask : pulse
    task automatic dreq(input logic [6:0] n, input logic exp);
        @(negedge mclk) data_node = n;
        data_request = 1'b1;
        @(negedge mclk) data_request = 1'b0;
        chk("data_grant", exp, data_grant);
    endtask : dreq
    task automatic t_reset();
        repeat (3) @(negedge mclk);
        chk("can_tx", 1'b1, can_tx);
        chk("tx_err_count", 9'h000, tx_err_count);
        rst = 1'b0;
        $display("test reset done");
    endtask : t_reset
    task automatic t_passive();
        pulse(7'h01, 16);
        chk("tx_err_count", 9'h080, tx_err_count);
        chk("error_passive", 1'b1, error_passive);
        pulse(7'h08, 1);
        chk("error_passive", 1'b0, error_passive);
        pulse(7'h04, 16);
        chk("error_passive", 1'b1, error_passive);
        pulse(7'h02, 1);
        chk("rx_err_count", 9'h081, rx_err_count);
        pulse(7'h10, 1);
        chk("rx_err_count", 9'h07F, rx_err_count);
        chk("error_passive", 1'b0, error_passive);
        $display("test passive done");
    endtask : t_passive
    task automatic t_busoff();
        pulse(7'h01, 16);
        chk("bus_off", 1'b0, bus_off);
        chk("can_tx", 1'b0, can_tx);
        pulse(7'h01, 2);
        chk("tx_err_count", 9'h107, tx_err_count);
        chk("can_tx", 1'b1, can_tx);
        pulse(7'h40, 1);
        chk("bus_off", 1'b1, bus_off);
        pulse(7'h20, 127);
        pulse(7'h60, 1);
        chk("bus_off", 1'b0, bus_off);
        chk("counts", 18'h00000, {tx_err_count, rx_err_count});
        $display("test bus-off done");
    endtask : t_busoff
    task automatic t_scan();
        @(negedge mclk) network_discovery_command = 1'b1;
        @(negedge mclk) network_discovery_command = 1'b0;
        repeat (60) @(negedge mclk);
        dreq(7'h03, 1'b0);
        for (int i = 0; i < 3000 && scan_done !== 1'b1; i++) @(negedge mclk);
        chk("scan_done", 1'b1, scan_done);
        @(negedge mclk);
        chk("scan_busy", 1'b0, scan_busy);
        chk("guards", 128'h7F, guards);
        chk("found_map", 128'h28, found_map);
        chk("connected_map", 128'h08, connected_map);
        dreq(7'h05, 1'b0);
        dreq(7'h03, 1'b1);
        @(negedge mclk) connect_node = 7'h05;
        connect_request = 1'b1;
        @(negedge mclk) connect_request = 1'b0;
        @(negedge mclk);
        chk("connected_map", 128'h28, connected_map);
        dreq(7'h05, 1'b1);
        $display("test scan done");
    endtask : t_scan
    task automatic t_devreset();
        pulse(7'h04, 32);
        chk("bus_off", 1'b1, bus_off);
        chk("rx_err_count", 9'h100, rx_err_count);
        @(negedge mclk) rst = 1'b1;
        repeat (3) @(negedge mclk);
        chk("can_tx", 1'b1, can_tx);
        rst = 1'b0;
        @(negedge mclk);
        chk("bus_off", 1'b0, bus_off);
        chk("counts", 18'h00000, {tx_err_count, rx_err_count});
        $display("test device reset done");
    endtask : t_devreset
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // watchdog, several times the expected run
    initial
    begin
        #(20000 * 5);
        miscompares++;
        wrap_up();
    end
    initial
    begin
        t_reset();
        t_passive();
        t_busoff();
        t_scan();
        t_devreset();
        wrap_up();
    end
endmodule : can_error_state_node_mgmt_tb
`default_nettype wire
